// file: core/phg_pkg.sv
`default_nettype none
package phg_pkg;
   // ----------------------------------------------------------------
   // health test figures
   // ----------------------------------------------------------------
   localparam int RUN_LIMIT = 32;   // identical raw bits taken as total loss
   localparam int WIN_LEN = 256;    // raw bits per statistical window
   localparam int ONES_LO = 96;     // least tolerated ones per window
   localparam int ONES_HI = 160;    // most tolerated ones per window
   // ----------------------------------------------------------------
   // word formats
   // ----------------------------------------------------------------
   localparam int WORD_NARROW = 8;
   localparam int WORD_WIDE = 16;
   localparam int GUARD_LEN = RUN_LIMIT; // raw bits a finished word waits
   // ----------------------------------------------------------------
   // generator states
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PHG_IDLE = 2'h0,
      PHG_STARTUP = 2'h1,
      PHG_RUN = 2'h2,
      PHG_FAILED = 2'h3
   } phg_state_type;
endpackage
`default_nettype wire

// file: core/phg_health.sv
`default_nettype none
module phg_health #(
   parameter int RUN_LIMIT = phg_pkg::RUN_LIMIT,
   parameter int WIN_LEN = phg_pkg::WIN_LEN,
   parameter int ONES_LO = phg_pkg::ONES_LO,
   parameter int ONES_HI = phg_pkg::ONES_HI
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic sample,
   input wire logic rawBit,
   output logic totalFail,
   output logic statFail,
   output logic windowPass
);
   localparam int RW = $clog2(RUN_LIMIT + 1);
   localparam int WW = $clog2(WIN_LEN + 1);

   logic lastBit, next_lastBit;
   logic [RW-1:0] runCount, next_runCount;
   logic [WW-1:0] winCount, next_winCount;
   logic [WW-1:0] onesCount, next_onesCount;
   logic [WW-1:0] onesNow;

   // ----------------------------------------------------------------
   // repetition and ones-count tests
   // ----------------------------------------------------------------
   always_comb
   begin
      next_lastBit = lastBit;
      next_runCount = runCount;
      next_winCount = winCount;
      next_onesCount = onesCount;
      totalFail = 1'b0;
      statFail = 1'b0;
      windowPass = 1'b0;
      onesNow = onesCount + {{(WW-1){1'b0}}, rawBit};
      if (clear)
      begin
         next_runCount = '0;
         next_winCount = '0;
         next_onesCount = '0;
      end
      else if (sample)
      begin
         next_lastBit = rawBit;
         // stuck source shows as a long run of one value
         if (rawBit == lastBit && runCount != '0)
            next_runCount = runCount + RW'(1);
         else
            next_runCount = RW'(1);
         if (next_runCount == RW'(RUN_LIMIT))
         begin
            totalFail = 1'b1;
            next_runCount = '0;
         end
         // window test runs on every raw bit, forever
         if (winCount == WW'(WIN_LEN - 1))
         begin
            if (onesNow < WW'(ONES_LO) || onesNow > WW'(ONES_HI))
               statFail = 1'b1;
            else
               windowPass = 1'b1;
            next_winCount = '0;
            next_onesCount = '0;
         end
         else
         begin
            next_winCount = winCount + WW'(1);
            next_onesCount = onesNow;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         lastBit <= 1'b0;
         runCount <= '0;
         winCount <= '0;
         onesCount <= '0;
      end
      else
      begin
         lastBit <= next_lastBit;
         runCount <= next_runCount;
         winCount <= next_winCount;
         onesCount <= next_onesCount;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_run_bounded;
      @(posedge ref_clk) disable iff (rst) runCount < RW'(RUN_LIMIT);
   endproperty
   a_run_bounded: assert property (p_run_bounded) else $error("run counter passed limit");

   property p_window_restarts;
      @(posedge ref_clk) disable iff (rst)
         (windowPass || statFail) |=> (winCount == '0 && onesCount == '0);
   endproperty
   a_window_restarts: assert property (p_window_restarts) else $error("window did not restart");

   property p_verdict_once;
      @(posedge ref_clk) disable iff (rst)
         (windowPass || statFail) |-> (!(windowPass && statFail) && winCount == WW'(WIN_LEN - 1));
   endproperty
   a_verdict_once: assert property (p_verdict_once) else $error("window verdict at wrong bit");
endmodule
`default_nettype wire

// file: core/phg_gate.sv
`default_nettype none
// Notes on behaviour
// - random words come only from the physical raw bit stream.
// - a stuck-source test starts on every raw bit once the generator starts.
// - after a total failure no random word leaves until restart.
// - a word touching bits near a failure is held back and dropped.
// - a ones-count window test runs on raw bits from start.
// - the window test keeps running for as long as the generator runs.
// - output stays blocked until a start window passes, and on any defect.
// - words are 8 or 16 bits wide, chosen at start.
// - every raw bit feeds the window test, so defects show within a window.
module phg_gate #(
   parameter int RUN_LIMIT = phg_pkg::RUN_LIMIT,
   parameter int WIN_LEN = phg_pkg::WIN_LEN,
   parameter int GUARD_LEN = phg_pkg::GUARD_LEN
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic rngEnable,
   input wire logic wordWide,
   input wire logic rawBit,
   input wire logic rawValid,
   output logic [15:0] rndWord,
   output logic rndValid,
   output logic startupDone,
   output logic failTotal,
   output logic failStat
);
   localparam int GW = $clog2(GUARD_LEN + 1);

   phg_pkg::phg_state_type state, next_state;
   logic wideMode, next_wideMode;
   logic [15:0] shiftReg, next_shiftReg;
   logic [4:0] bitCount, next_bitCount;
   logic [15:0] pendWord, next_pendWord;
   logic pending, next_pending;
   logic [GW-1:0] guardCount, next_guardCount;
   logic [15:0] next_rndWord;
   logic next_rndValid, next_startupDone, next_failTotal, next_failStat;
   logic active, sample, healthClear;
   logic healthTotal, healthStat, healthPass;
   logic [4:0] wordLen;

   assign active = (state == phg_pkg::PHG_STARTUP) || (state == phg_pkg::PHG_RUN);
   assign sample = active && rawValid;
   assign healthClear = (state == phg_pkg::PHG_IDLE);
   assign wordLen = wideMode ? 5'(phg_pkg::WORD_WIDE) : 5'(phg_pkg::WORD_NARROW);

   // ----------------------------------------------------------------
   // health tests on the raw stream
   // ----------------------------------------------------------------
   phg_health #(
      .RUN_LIMIT(RUN_LIMIT),
      .WIN_LEN(WIN_LEN),
      .ONES_LO(phg_pkg::ONES_LO),
      .ONES_HI(phg_pkg::ONES_HI)
   ) u_health (
      .ref_clk(ref_clk),
      .rst(rst),
      .clear(healthClear),
      .sample(sample),
      .rawBit(rawBit),
      .totalFail(healthTotal),
      .statFail(healthStat),
      .windowPass(healthPass)
   );

   // ----------------------------------------------------------------
   // state, word assembly and output gate
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_wideMode = wideMode;
      next_shiftReg = shiftReg;
      next_bitCount = bitCount;
      next_pendWord = pendWord;
      next_pending = pending;
      next_guardCount = guardCount;
      next_rndWord = rndWord;
      next_rndValid = 1'b0;
      next_startupDone = startupDone;
      next_failTotal = failTotal;
      next_failStat = failStat;
      unique case (state)
         phg_pkg::PHG_IDLE:
         begin
            if (rngEnable)
            begin
               next_state = phg_pkg::PHG_STARTUP;
               next_wideMode = wordWide;
               next_failTotal = 1'b0;
               next_failStat = 1'b0;
            end
         end
         phg_pkg::PHG_STARTUP:
         begin
            if (healthPass)
            begin
               next_state = phg_pkg::PHG_RUN;
               next_startupDone = 1'b1;
            end
         end
         phg_pkg::PHG_RUN:
         begin
            // assemble raw bits while no word waits
            if (sample && !pending)
            begin
               next_shiftReg = {shiftReg[14:0], rawBit};
               if (bitCount + 5'(1) == wordLen)
               begin
                  next_pendWord = wideMode ? next_shiftReg : {8'h00, next_shiftReg[7:0]};
                  next_pending = 1'b1;
                  next_guardCount = '0;
                  next_bitCount = '0;
               end
               else
                  next_bitCount = bitCount + 5'(1);
            end
            // finished word waits for later bits to pass the stuck test
            else if (sample && pending && guardCount != GW'(GUARD_LEN))
               next_guardCount = guardCount + GW'(1);
            if (pending && guardCount == GW'(GUARD_LEN) && !healthTotal && !healthStat)
            begin
               next_rndWord = pendWord;
               next_rndValid = 1'b1;
               next_pending = 1'b0;
            end
            if (healthStat)
            begin
               next_state = phg_pkg::PHG_STARTUP;
               next_startupDone = 1'b0;
            end
         end
         phg_pkg::PHG_FAILED:
         begin
         end
      endcase
      // sticky flags; the set wins over the restart clear
      if (active && healthStat)
         next_failStat = 1'b1;
      if (active && healthTotal)
      begin
         next_failTotal = 1'b1;
         next_state = phg_pkg::PHG_FAILED;
         next_startupDone = 1'b0;
      end
      // any block drops the partial and waiting word
      if (next_state != phg_pkg::PHG_RUN)
      begin
         next_pending = 1'b0;
         next_bitCount = '0;
      end
      if (!rngEnable)
      begin
         next_state = phg_pkg::PHG_IDLE;
         next_startupDone = 1'b0;
         next_rndValid = 1'b0;
         next_pending = 1'b0;
         next_bitCount = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= phg_pkg::PHG_IDLE;
         wideMode <= 1'b0;
         shiftReg <= 16'h0000;
         bitCount <= 5'h00;
         pendWord <= 16'h0000;
         pending <= 1'b0;
         guardCount <= '0;
         rndWord <= 16'h0000;
         rndValid <= 1'b0;
         startupDone <= 1'b0;
         failTotal <= 1'b0;
         failStat <= 1'b0;
      end
      else
      begin
         state <= next_state;
         wideMode <= next_wideMode;
         shiftReg <= next_shiftReg;
         bitCount <= next_bitCount;
         pendWord <= next_pendWord;
         pending <= next_pending;
         guardCount <= next_guardCount;
         rndWord <= next_rndWord;
         rndValid <= next_rndValid;
         startupDone <= next_startupDone;
         failTotal <= next_failTotal;
         failStat <= next_failStat;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_start;
      state == phg_pkg::PHG_IDLE && rngEnable;
   endsequence

   sequence s_total_seen;
      active && healthTotal && rngEnable;
   endsequence

   property p_start_tests;
      @(posedge ref_clk) disable iff (rst) s_start |=> state == phg_pkg::PHG_STARTUP;
   endproperty
   a_start_tests: assert property (p_start_tests) else $error("start did not begin tests");

   property p_total_blocks;
      @(posedge ref_clk) disable iff (rst) s_total_seen |=> (state == phg_pkg::PHG_FAILED && failTotal) ##1 failTotal;
   endproperty
   a_total_blocks: assert property (p_total_blocks) else $error("total failure not latched");

   property p_no_word_after_total;
      @(posedge ref_clk) disable iff (rst) failTotal |-> !rndValid;
   endproperty
   a_no_word_after_total: assert property (p_no_word_after_total) else $error("word after total failure");

   property p_word_guarded;
      @(posedge ref_clk) disable iff (rst)
         rndValid |-> $past(pending) && $past(guardCount) == GW'(GUARD_LEN) && !$past(healthTotal);
   endproperty
   a_word_guarded: assert property (p_word_guarded) else $error("word released without guard");

   property p_blocked_before_pass;
      @(posedge ref_clk) disable iff (rst) rndValid |-> startupDone && state == phg_pkg::PHG_RUN;
   endproperty
   a_blocked_before_pass: assert property (p_blocked_before_pass) else $error("word before start pass");

   property p_defect_retests;
      @(posedge ref_clk) disable iff (rst)
         (state == phg_pkg::PHG_RUN && healthStat && !healthTotal && rngEnable)
            |=> state == phg_pkg::PHG_STARTUP && failStat && !rndValid;
   endproperty
   a_defect_retests: assert property (p_defect_retests) else $error("defect did not block output");

   property p_narrow_word;
      @(posedge ref_clk) disable iff (rst) (rndValid && !wideMode) |-> rndWord[15:8] == 8'h00;
   endproperty
   a_narrow_word: assert property (p_narrow_word) else $error("narrow word has high bits");

   property p_sticky_stat;
      @(posedge ref_clk) disable iff (rst) (failStat && !(state == phg_pkg::PHG_IDLE)) |=> failStat;
   endproperty
   a_sticky_stat: assert property (p_sticky_stat) else $error("defect flag lost");
endmodule
`default_nettype wire

// file: verification/phg_gate_tb.sv
`default_nettype none
module phg_gate_tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(got, exp, msg) \
      begin \
         check_count++; \
         if ((got) !== (exp)) \
         begin \
            failures++; \
            $display("[FAIL] %0t %s", $time, msg); \
         end \
      end
   // ----------------------------------------------------------------
   // signals and model state
   // ----------------------------------------------------------------
   logic ref_clk;
   logic rst;
   logic rngEnable;
   logic wordWide;
   logic rawBit;
   logic rawValid;
   logic [15:0] rndWord;
   logic rndValid;
   logic startupDone;
   logic failTotal;
   logic failStat;
   int failures;
   int check_count;
   int cycles;
   int wordCnt;
   integer seed;
   int mState;
   int runLen;
   int lastBit;
   int winCnt;
   int onesCnt;
   int bitCnt;
   int guardCnt;
   int wlen;
   bit pending;
   bit gapReq;
   logic mTotal;
   logic mStat;
   logic [15:0] acc;
   logic [15:0] expQ[$];
   phg_gate #(
      .RUN_LIMIT(phg_pkg::RUN_LIMIT),
      .WIN_LEN(phg_pkg::WIN_LEN),
      .GUARD_LEN(phg_pkg::GUARD_LEN)
   ) u_phg_gate (
      .ref_clk(ref_clk),
      .rst(rst),
      .rngEnable(rngEnable),
      .wordWide(wordWide),
      .rawBit(rawBit),
      .rawValid(rawValid),
      .rndWord(rndWord),
      .rndValid(rndValid),
      .startupDone(startupDone),
      .failTotal(failTotal),
      .failStat(failStat)
   );
   // clock generation
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // reference model, one raw bit at a time
   // ----------------------------------------------------------------
   task automatic model_bit(input int b);
      bit tf;
      bit wf;
      bit wp;
      begin
         if (mState == 1 || mState == 2)
         begin
            runLen = (b == lastBit) ? runLen + 1 : 1;
            lastBit = b;
            tf = (runLen >= phg_pkg::RUN_LIMIT);
            winCnt++;
            onesCnt += b;
            wf = 1'b0;
            wp = 1'b0;
            if (winCnt == phg_pkg::WIN_LEN)
            begin
               wf = (onesCnt < phg_pkg::ONES_LO) || (onesCnt > phg_pkg::ONES_HI);
               wp = !wf;
               winCnt = 0;
               onesCnt = 0;
            end
            if (tf)
            begin
               mState = 3;
               mTotal = 1'b1;
               pending = 1'b0;
               bitCnt = 0;
            end
            else if (wf)
            begin
               mState = 1;
               mStat = 1'b1;
               pending = 1'b0;
               bitCnt = 0;
            end
            else if (mState == 1)
            begin
               if (wp)
                  mState = 2;
            end
            else if (pending)
            begin
               guardCnt++;
               if (guardCnt == phg_pkg::GUARD_LEN)
               begin
                  expQ.push_back(acc);
                  pending = 1'b0;
                  gapReq = 1'b1;
               end
            end
            else
            begin
               if (bitCnt == 0)
                  acc = 16'h0000;
               acc = {acc[14:0], b[0]};
               bitCnt++;
               if (bitCnt == wlen)
               begin
                  pending = 1'b1;
                  guardCnt = 0;
                  bitCnt = 0;
               end
            end
         end
      end
   endtask
   // ----------------------------------------------------------------
   // stimulus tasks
   // ----------------------------------------------------------------
   // restart the generator, width chosen at start
   task automatic start(input bit wide);
      begin
         @(posedge ref_clk);
         rngEnable <= 1'b0;
         @(posedge ref_clk);
         rngEnable <= 1'b1;
         wordWide <= wide;
         mState = 1;
         runLen = 0;
         lastBit = -1;
         winCnt = 0;
         onesCnt = 0;
         bitCnt = 0;
         pending = 1'b0;
         mTotal = 1'b0;
         mStat = 1'b0;
         wlen = wide ? 16 : 8;
         repeat (2) @(posedge ref_clk);
      end
   endtask
   // mode 0 random, 1 ones, 2 zeros, 3 sparse ones
   task automatic send(input int n, input int mode);
      int b;
      begin
         for (int i = 0; i < n; i++)
         begin
            b = (mode == 0) ? ($random(seed) & 1) : (mode == 1) ? 1 : (mode == 2) ? 0 : int'(i % 8 == 0);
            @(posedge ref_clk);
            rawBit <= b[0];
            rawValid <= 1'b1;
            model_bit(b);
            if (gapReq)
            begin
               gapReq = 1'b0;
               @(posedge ref_clk);
               rawValid <= 1'b0;
               repeat (3) @(posedge ref_clk);
            end
         end
         @(posedge ref_clk);
         rawValid <= 1'b0;
         repeat (8) @(posedge ref_clk);
         `CHK({failTotal, failStat}, {mTotal, mStat}, "flags differ from model")
         `CHK(startupDone, logic'(mState == 2), "gate state differs from model")
      end
   endtask
   task automatic summarize;
      begin
         $display("comparisons %0d mismatches %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // word monitor and timeout
   // ----------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (rndValid === 1'b1)
      begin
         wordCnt++;
         if (expQ.size() == 0)
            `CHK(1'b1, 1'b0, "word while blocked")
         else
            `CHK(rndWord, expQ.pop_front(), "word value")
      end
      cycles++;
      if (cycles > 15000)
      begin
         failures++;
         $display("[FAIL] %0t timeout", $time);
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 88177;
      rst = 1'b1;
      rngEnable = 1'b0;
      wordWide = 1'b0;
      rawBit = 1'b0;
      rawValid = 1'b0;
      gapReq = 1'b0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      `CHK({rndValid, startupDone, failTotal, failStat}, 4'h0, "reset outputs")
      // narrow words, no output before the start window
      start(1'b0);
      send(200, 0);
      `CHK(startupDone, 1'b0, "early start done")
      send(600, 0);
      `CHK(startupDone, logic'(mState == 2), "start done")
      `CHK(wordCnt > 3, 1'b1, "too few narrow words")
      `CHK(expQ.size(), 0, "narrow words missing")
      $display("test narrow words done");
      // wide words
      wordCnt = 0;
      start(1'b1);
      send(700, 0);
      `CHK(wordCnt > 3, 1'b1, "too few wide words")
      `CHK(expQ.size(), 0, "wide words missing")
      $display("test wide words done");
      // statistical defect while running, then recovery
      start(1'b1);
      send(300, 0);
      send(212, 3);
      `CHK(failStat, 1'b1, "defect not flagged")
      `CHK(startupDone, 1'b0, "output not blocked")
      wordCnt = 0;
      send(512, 0);
      `CHK(failStat, 1'b1, "defect flag not sticky")
      `CHK(startupDone, logic'(mState == 2), "no requalify")
      `CHK(wordCnt > 0, 1'b1, "no words after recovery")
      `CHK(expQ.size(), 0, "words missing after recovery")
      $display("test defect done");
      // total failure while running
      start(1'b0);
      send(300, 0);
      send(40, 1);
      `CHK(failTotal, 1'b1, "stuck source missed")
      `CHK(startupDone, 1'b0, "failed but running")
      send(300, 0);
      `CHK(expQ.size(), 0, "word queue after failure")
      $display("test run failure done");
      // total failure right at start
      start(1'b1);
      send(40, 2);
      `CHK(failTotal, 1'b1, "start stuck missed")
      `CHK(failStat, 1'b0, "false defect")
      $display("test start failure done");
      // restart clears the flags
      start(1'b0);
      `CHK({failTotal, failStat}, 2'h0, "flags not cleared")
      wordCnt = 0;
      send(500, 0);
      `CHK(wordCnt > 0, 1'b1, "no words after restart")
      `CHK(expQ.size(), 0, "words missing after restart")
      $display("test restart done");
      summarize();
   end
endmodule
`default_nettype wire
